// ---- core/ppfs_sync.sv ----
// two-flop synchroniser for a vector of unrelated levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
`default_nettype none
module ppfs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ---- core/ppfs_top.sv ----
// per-pin function selection for ports a to e, reset pin and bus-side strobes
// assumes config, macrocell, chip-select, test and read data come from clk logic
// How it works
// - while the reset pin is low, pin drivers, captured inputs, strobes and config return to reset.
// - reset asserted while a flash program or erase runs raises the abort output.
// - port a pins serve as mcu io, macrocell group a outputs or latched/transparent/registered inputs.
// - port b pins offer the same choices with macrocell group b outputs.
// - port c pins serve as mcu io, external chip-select outputs or logic inputs.
// - pd0 as address strobe latches the address/data port, on the rising edge in strobe mode.
// - pd1 as logic clock input produces the tick for macrocells, power-down counter and array.
// - pd2 as chip-select input low enables memory access, high disables the memories.
// - a falling edge on the chip-select input pulses the wake from power-down.
// - pd3 as high-byte write strobe accepts the upper data byte when it goes low and returns.
// - port e pins 0 to 5 carry the test port, inputs passed in and status outputs driven out.
// - pe4 can drive the ready/busy status of parallel programming.
// - every port e pin can be mcu io or a latched address output.
// - pd0 to pd3 can be mcu io or transparent logic inputs.
// - the address/data port is driven only while read is active and a block is selected.
`timescale 1ns/1ps
`default_nettype none
module ppfs_top (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        resetPinN,
	input  wire ppfs_pkg::ppfs_cfg_t         cfgIn,
	input  wire ppfs_pkg::ppfs_pins_t        pinIn,
	output var  ppfs_pkg::ppfs_pins_t        pinOut_r,
	output var  ppfs_pkg::ppfs_pins_t        pinOe_r,
	input  wire ppfs_pkg::ppfs_pins_t        mcuOut,
	input  wire ppfs_pkg::ppfs_pins_t        mcuOe,
	output var  ppfs_pkg::ppfs_pins_t        mcuPinIn_r,
	output var  ppfs_pkg::ppfs_pins_t        logicInput_r,
	input  wire logic [7:0]                  macrocellOutGroupA,
	input  wire logic [7:0]                  macrocellOutGroupB,
	input  wire logic [7:0]                  externalChipSelectOut,
	input  wire ppfs_pkg::ppfs_test_t        testIn,
	output var  logic                        testTms_r,
	output var  logic                        testTck_r,
	output var  logic                        testTdi_r,
	input  wire logic [ppfs_pkg::AD_W-1:0]   muxAddrDataIn,
	output var  logic [ppfs_pkg::AD_W-1:0]   muxAddrDataOut_r,
	output var  logic                        muxAddrDataOe_r,
	input  wire logic                        readStrobeN,
	input  wire logic                        blockSelected,
	input  wire logic [ppfs_pkg::AD_W-1:0]   readData,
	output var  logic [ppfs_pkg::AD_W-1:0]   latchedAddr_r,
	output var  logic                        logicClockTick_r,
	output var  logic                        memAccessEn_r,
	output var  logic                        wakeFromPowerDown_r,
	output var  logic                        highByteWrite_r,
	output var  logic [ppfs_pkg::HI_W-1:0]   highByteData_r,
	input  wire logic                        nvmBusy,
	output var  logic                        nvmAbort_r
);
	import ppfs_pkg::*;

	localparam int SYNC_W = PIN_W + 2 + AD_W;

	// ==========================================================
	// decode helpers
	function automatic logic fnIs(input logic [1:0] code, input ppfs_fn_t fn);
		fnIs = (code == fn);
	endfunction

	function automatic logic [PORT_W-1:0] pickIn(
		input logic [1:0]        mode,
		input logic [PORT_W-1:0] tVal,
		input logic [PORT_W-1:0] lVal,
		input logic [PORT_W-1:0] rVal
	);
		case (mode)
			IN_LATCHED:    pickIn = lVal;
			IN_REGISTERED: pickIn = rVal;
			default:       pickIn = tVal;
		endcase
	endfunction

	// ==========================================================
	// synchronised pins
	ppfs_pins_t        pinS;
	ppfs_pins_t        pinP_r;
	logic              resetPinS;
	logic              readStrobeS;
	logic [AD_W-1:0]   adS;
	ppfs_cfg_t         cfg_r;
	ppfs_pins_t        pinLatch_r;
	ppfs_pins_t        pinReg_r;

	ppfs_sync #(
		.WIDTH(SYNC_W)
	) uSync (
		.clk(clk),
		.rst(rst),
		.d  ({pinIn, resetPinN, readStrobeN, muxAddrDataIn}),
		.q  ({pinS, resetPinS, readStrobeS, adS})
	);

	wire devRst = rst | ~resetPinS;

	// ==========================================================
	// per-pin function masks
	logic [PIN_W-1:0][1:0] codes;
	ppfs_pins_t            isMcu;
	ppfs_pins_t            isAlt;
	ppfs_pins_t            isIn;
	ppfs_pins_t            isAux;

	assign codes = {cfg_r.a, cfg_r.b, cfg_r.c, cfg_r.d, cfg_r.e};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : gMask
			assign isMcu[gi] = fnIs(codes[gi], FN_MCU);
			assign isAlt[gi] = fnIs(codes[gi], FN_ALT);
			assign isIn[gi]  = fnIs(codes[gi], FN_INPUT);
			assign isAux[gi] = fnIs(codes[gi], FN_AUX);
		end
	endgenerate

	// ==========================================================
	// port d special functions
	wire asSel   = isAlt.d[PD_ASTROBE];
	wire lclkSel = isAlt.d[PD_LCLK];
	wire cselSel = isAlt.d[PD_CSEL];
	wire hiwrSel = isAlt.d[PD_HIWR];
	wire asRise  = pinS.d[PD_ASTROBE] & ~pinP_r.d[PD_ASTROBE];
	wire addrLatchEv = asSel & (cfg_r.asRising ? asRise : pinS.d[PD_ASTROBE]);
	wire lclkRise = lclkSel & pinS.d[PD_LCLK] & ~pinP_r.d[PD_LCLK];
	wire cselFall = cselSel & ~pinS.d[PD_CSEL] & pinP_r.d[PD_CSEL];
	wire hiwrDone = hiwrSel & pinS.d[PD_HIWR] & ~pinP_r.d[PD_HIWR];
	wire testOn   = &{isIn.e[PE_ERR], isIn.e[PE_STAT], isIn.e[PE_TDO]};

	// ==========================================================
	// pin drive selection
	ppfs_pins_t altVal;
	ppfs_pins_t altOe;
	ppfs_pins_t auxVal;
	ppfs_pins_t auxOe;
	ppfs_pins_t inVal;
	ppfs_pins_t inOe;
	ppfs_pins_t outNxt;
	ppfs_pins_t oeNxt;
	ppfs_pins_t logicSrc;

	// macrocell a / macrocell b / chip selects / latched address on port e
	assign altVal = {macrocellOutGroupA, macrocellOutGroupB, externalChipSelectOut,
		{PORTD_W{1'b0}}, latchedAddr_r[LADDR_W-1:0]};
	assign altOe  = {{PORT_W{1'b1}}, {PORT_W{1'b1}}, {PORT_W{1'b1}},
		{PORTD_W{1'b0}}, {PORT_W{1'b1}}};
	// test port outputs on pe3..pe5 when those pins select the test function
	always_comb begin
		inVal = '0;
		inOe  = '0;
		auxVal = '0;
		auxOe  = '0;
		inVal.e[PE_TDO]  = testIn.tdo;
		inVal.e[PE_STAT] = testIn.status;
		inVal.e[PE_ERR]  = testIn.errN;
		inOe.e[PE_TDO]   = 1'b1;
		inOe.e[PE_STAT]  = 1'b1;
		inOe.e[PE_ERR]   = 1'b1;
		auxVal.e[PE_STAT] = testIn.readyBusy;
		auxOe.e[PE_STAT]  = 1'b1;
	end

	assign outNxt = (isMcu & mcuOut) | (isAlt & altVal) | (isIn & inVal) | (isAux & auxVal);
	assign oeNxt  = (isMcu & mcuOe) | (isAlt & altOe) | (isIn & inOe) | (isAux & auxOe);

	assign logicSrc = {
		pickIn(cfg_r.modeA, pinS.a, pinLatch_r.a, pinReg_r.a),
		pickIn(cfg_r.modeB, pinS.b, pinLatch_r.b, pinReg_r.b),
		pickIn(cfg_r.modeC, pinS.c, pinLatch_r.c, pinReg_r.c),
		pinS.d,
		{PORT_W{1'b0}}};

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (devRst) begin
			cfg_r      <= '0;
			pinP_r     <= '0;
			pinLatch_r <= '0;
			pinReg_r   <= '0;
			pinOut_r   <= '0;
			pinOe_r    <= '0;
		end else begin
			cfg_r      <= cfgIn;
			pinP_r     <= pinS;
			pinLatch_r <= addrLatchEv ? pinS : pinLatch_r;
			pinReg_r   <= lclkRise ? pinS : pinReg_r;
			pinOut_r   <= outNxt;
			pinOe_r    <= oeNxt;
		end
	end

	always_ff @(posedge clk) begin
		if (devRst) begin
			mcuPinIn_r   <= '0;
			logicInput_r <= '0;
			testTms_r    <= 1'b0;
			testTck_r    <= 1'b0;
			testTdi_r    <= 1'b0;
		end else begin
			mcuPinIn_r   <= pinS & isMcu;
			logicInput_r <= logicSrc & isIn;
			testTms_r    <= pinS.e[PE_TMS] & isIn.e[PE_TMS];
			testTck_r    <= pinS.e[PE_TCK] & isIn.e[PE_TCK];
			testTdi_r    <= pinS.e[PE_TDI] & isIn.e[PE_TDI];
		end
	end

	always_ff @(posedge clk) begin
		if (devRst) begin
			latchedAddr_r       <= '0;
			logicClockTick_r    <= 1'b0;
			memAccessEn_r       <= 1'b0;
			wakeFromPowerDown_r <= 1'b0;
			highByteWrite_r     <= 1'b0;
			highByteData_r      <= '0;
			muxAddrDataOut_r    <= '0;
			muxAddrDataOe_r     <= 1'b0;
		end else begin
			latchedAddr_r       <= addrLatchEv ? adS : latchedAddr_r;
			logicClockTick_r    <= lclkRise;
			memAccessEn_r       <= ~cselSel | ~pinS.d[PD_CSEL];
			wakeFromPowerDown_r <= cselFall;
			highByteWrite_r     <= hiwrDone;
			highByteData_r      <= hiwrDone ? adS[HI_LSB +: HI_W] : highByteData_r;
			muxAddrDataOut_r    <= readData;
			muxAddrDataOe_r     <= ~readStrobeS & blockSelected;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			nvmAbort_r <= 1'b0;
		end else begin
			nvmAbort_r <= ~resetPinS & nvmBusy;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_resetQuiet;
		devRst |=> (pinOe_r == '0) && !muxAddrDataOe_r && !logicClockTick_r;
	endproperty
	a_resetQuiet: assert property (p_resetQuiet) else $error("outputs active during reset");

	property p_abort;
		!resetPinS && nvmBusy |=> nvmAbort_r;
	endproperty
	a_abort: assert property (p_abort) else $error("program not aborted by reset");

	property p_macroA;
		!devRst && isAlt.a[0] |=> pinOe_r.a[0] && pinOut_r.a[0] == $past(macrocellOutGroupA[0]);
	endproperty
	a_macroA: assert property (p_macroA) else $error("macrocell a not on pin");

	property p_chipSel;
		!devRst && isAlt.c[7] |=> pinOut_r.c[7] == $past(externalChipSelectOut[7]);
	endproperty
	a_chipSel: assert property (p_chipSel) else $error("chip select not on pin");

	sequence s_strobeRise;
		!devRst && asSel && cfg_r.asRising && asRise;
	endsequence
	property p_addrLatch;
		s_strobeRise |=> latchedAddr_r == $past(adS) ##1
			$stable(latchedAddr_r) || $rose(pinS.d[0]) || $past(devRst);
	endproperty
	a_addrLatch: assert property (p_addrLatch) else $error("address not latched");

	property p_clockTick;
		!devRst && lclkRise |=> logicClockTick_r ##1 !logicClockTick_r;
	endproperty
	a_clockTick: assert property (p_clockTick) else $error("logic clock tick wrong");

	property p_memOff;
		!devRst && cselSel && pinS.d[PD_CSEL] |=> !memAccessEn_r;
	endproperty
	a_memOff: assert property (p_memOff) else $error("memories not disabled");

	property p_wake;
		!devRst && cselSel && $fell(pinS.d[PD_CSEL]) && !$past(devRst) |=> wakeFromPowerDown_r;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on falling select");

	property p_hiByte;
		!devRst && hiwrDone |=> highByteWrite_r && highByteData_r == $past(adS[HI_LSB +: HI_W]);
	endproperty
	a_hiByte: assert property (p_hiByte) else $error("high byte not accepted");

	property p_testOut;
		!devRst && testOn |=> pinOe_r.e[PE_TDO] && pinOut_r.e[PE_ERR] == $past(testIn.errN);
	endproperty
	a_testOut: assert property (p_testOut) else $error("test port output wrong");

	property p_oneFunc;
		!devRst |=> (mcuPinIn_r & ~$past(isMcu)) == '0 && (logicInput_r & ~$past(isIn)) == '0;
	endproperty
	a_oneFunc: assert property (p_oneFunc) else $error("unselected function sees pin");

	property p_adDrive;
		muxAddrDataOe_r |-> !$past(readStrobeS) && $past(blockSelected) && !$past(devRst);
	endproperty
	a_adDrive: assert property (p_adDrive) else $error("bus driven without read");
endmodule
`default_nettype wire

// ---- include/ppfs_pkg.sv ----
// constants and carrier types for the port pin function selector
// assumes a single 25 MHz clock domain; pins arrive unsynchronised
`default_nettype none
package ppfs_pkg;
	// ==========================================================
	// widths
	localparam int PORT_W  = 8;
	localparam int PORTD_W = 4;
	localparam int AD_W    = 16;
	localparam int PIN_W   = 4 * PORT_W + PORTD_W - PORT_W + PORT_W;
	localparam int LADDR_W = 8;
	localparam int HI_LSB  = 8;
	localparam int HI_W    = 8;
	// ==========================================================
	// port d special pins
	localparam int PD_ASTROBE = 0;
	localparam int PD_LCLK    = 1;
	localparam int PD_CSEL    = 2;
	localparam int PD_HIWR    = 3;
	// ==========================================================
	// port e test port pins
	localparam int PE_TMS  = 0;
	localparam int PE_TCK  = 1;
	localparam int PE_TDI  = 2;
	localparam int PE_TDO  = 3;
	localparam int PE_STAT = 4;
	localparam int PE_ERR  = 5;
	// ==========================================================
	// per-pin function codes and logic input modes
	typedef enum logic [1:0] {FN_MCU, FN_ALT, FN_INPUT, FN_AUX} ppfs_fn_t;
	typedef enum logic [1:0] {IN_TRANSPARENT, IN_LATCHED, IN_REGISTERED} ppfs_inmode_t;
	localparam logic [1:0] FN_RESET = 2'h0;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [PORT_W-1:0]  a;
		logic [PORT_W-1:0]  b;
		logic [PORT_W-1:0]  c;
		logic [PORTD_W-1:0] d;
		logic [PORT_W-1:0]  e;
	} ppfs_pins_t;

	typedef struct packed {
		logic [PORT_W-1:0][1:0]  a;
		logic [PORT_W-1:0][1:0]  b;
		logic [PORT_W-1:0][1:0]  c;
		logic [PORTD_W-1:0][1:0] d;
		logic [PORT_W-1:0][1:0]  e;
		logic [1:0]              modeA;
		logic [1:0]              modeB;
		logic [1:0]              modeC;
		logic                    asRising;
	} ppfs_cfg_t;

	typedef struct packed {
		logic tdo;
		logic status;
		logic errN;
		logic readyBusy;
	} ppfs_test_t;
endpackage
`default_nettype wire

// ---- verif/ppfs_far_end.sv ----
// far side of the pin selector: mcu bus pads and test-port programmer
// assumes the bench gives the level that the far side puts on each pin
`timescale 1ns/1ps
`default_nettype none
module ppfs_far_end (
	input  wire ppfs_pkg::ppfs_pins_t dutOut,
	input  wire ppfs_pkg::ppfs_pins_t dutOe,
	input  wire ppfs_pkg::ppfs_pins_t farVal,
	output var  ppfs_pkg::ppfs_pins_t pad
);
	import ppfs_pkg::*;
	// ==========================================================
	// pad level: device drive wins, else strobes and test inputs from far side
	always_comb begin
		pad = (dutOut & dutOe) | (farVal & ~dutOe);
	end
endmodule
`default_nettype wire

// ---- verif/ppfs_top_bench.sv ----
// self-checking bench for the port pin function selector
// assumes one 25 MHz clock; far side pads come from ppfs_far_end
`timescale 1ns/1ps
`default_nettype none
module ppfs_top_bench;
	import ppfs_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            resetPinN = 1'b1;
	logic            readStrobeN = 1'b1;
	logic            blockSelected = 1'b0;
	logic            nvmBusy = 1'b0;
	ppfs_cfg_t       cfgIn = '0;
	ppfs_pins_t      farVal = '0;
	ppfs_pins_t      mcuOut = '0;
	ppfs_pins_t      mcuOe = '0;
	ppfs_test_t      testIn = '0;
	logic [7:0]      mcA = 8'h00;
	logic [7:0]      mcB = 8'h00;
	logic [7:0]      ecs = 8'h00;
	logic [AD_W-1:0] adIn = 16'h0000;
	logic [AD_W-1:0] rdData = 16'h0000;
	ppfs_pins_t      pinIn, pinOut, pinOe, mcuPinIn, logicIn;
	logic            tms, tck, tdi, adOe, tick, memEn, wake, hiWr, abort;
	logic [AD_W-1:0] adOut, latAddr;
	logic [HI_W-1:0] hiData;
	logic [31:0]     seed = 32'hE46427C4;
	logic [15:0]     expAddr = 16'h0000;
	int              mismatches = 0;
	int              numChecks = 0;
	int              ticks, wakes, hiWrs;

	always #20 clk = ~clk;

	ppfs_top DUT (.clk(clk), .rst(rst), .resetPinN(resetPinN), .cfgIn(cfgIn),
		.pinIn(pinIn), .pinOut_r(pinOut), .pinOe_r(pinOe), .mcuOut(mcuOut),
		.mcuOe(mcuOe), .mcuPinIn_r(mcuPinIn), .logicInput_r(logicIn),
		.macrocellOutGroupA(mcA), .macrocellOutGroupB(mcB),
		.externalChipSelectOut(ecs), .testIn(testIn), .testTms_r(tms),
		.testTck_r(tck), .testTdi_r(tdi), .muxAddrDataIn(adIn),
		.muxAddrDataOut_r(adOut), .muxAddrDataOe_r(adOe),
		.readStrobeN(readStrobeN), .blockSelected(blockSelected),
		.readData(rdData), .latchedAddr_r(latAddr), .logicClockTick_r(tick),
		.memAccessEn_r(memEn), .wakeFromPowerDown_r(wake),
		.highByteWrite_r(hiWr), .highByteData_r(hiData), .nvmBusy(nvmBusy),
		.nvmAbort_r(abort));

	ppfs_far_end farEnd (.dutOut(pinOut), .dutOe(pinOe), .farVal(farVal), .pad(pinIn));

	// ==========================================================
	// pulse counters
	always @(posedge clk) begin
		if (tick === 1'b1) ticks++;
		if (wake === 1'b1) wakes++;
		if (hiWr === 1'b1) hiWrs++;
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// pins whose function code equals k
	function automatic ppfs_pins_t fm(input ppfs_cfg_t c, input logic [1:0] k);
		fm = '0;
		for (int i = 0; i < 8; i++) begin
			fm.a[i] = c.a[i] == k;
			fm.b[i] = c.b[i] == k;
			fm.c[i] = c.c[i] == k;
			fm.e[i] = c.e[i] == k;
			if (i < 4) fm.d[i] = c.d[i] == k;
		end
	endfunction

	// expected {enable, value} of one port from per-code enable and value tables
	function automatic logic [15:0] ed(input logic [7:0][1:0] f,
		input logic [3:0][7:0] oe4, input logic [3:0][7:0] v4);
		for (int i = 0; i < 8; i++) begin
			ed[8+i] = oe4[f[i]][i];
			ed[i] = v4[f[i]][i] & oe4[f[i]][i];
		end
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		numChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic randAll();
		logic [95:0] r;
		r = {xs(), xs(), xs()};
		cfgIn = r[$bits(ppfs_cfg_t)-1:0];
		cfgIn.modeA = 2'h0;
		cfgIn.modeB = 2'h0;
		cfgIn.modeC = 2'h0;
		cfgIn.asRising = 1'b1;
		cfgIn.d[0] = cfgIn.d[0] & 2'h2;
		r = {xs(), xs(), xs()};
		{ecs, mcB, mcA, mcuOut, farVal} = r;
		r = {xs(), xs(), xs()};
		{adIn, nvmBusy, rdData, blockSelected, readStrobeN, testIn, mcuOe} = r[74:0];
	endtask

	task automatic chkPins();
		logic [15:0] ra, rb, rc, rd, re;
		ppfs_pins_t  m0, m2;
		ra = ed(cfgIn.a, {16'h0, 8'hFF, mcuOe.a}, {16'h0, mcA, mcuOut.a});
		rb = ed(cfgIn.b, {16'h0, 8'hFF, mcuOe.b}, {16'h0, mcB, mcuOut.b});
		rc = ed(cfgIn.c, {16'h0, 8'hFF, mcuOe.c}, {16'h0, ecs, mcuOut.c});
		rd = ed({8'h0, cfgIn.d}, {28'h0, mcuOe.d}, {28'h0, mcuOut.d});
		re = ed(cfgIn.e, {8'h10, 8'h38, 8'hFF, mcuOe.e}, {3'h0, testIn.readyBusy, 6'h0,
			testIn.errN, testIn.status, testIn.tdo, 3'h0, expAddr[7:0], mcuOut.e});
		m0 = fm(cfgIn, 2'h0);
		m2 = fm(cfgIn, 2'h2);
		chk(pinOe, {ra[15:8], rb[15:8], rc[15:8], rd[11:8], re[15:8]});
		chk(pinOut & pinOe, {ra[7:0], rb[7:0], rc[7:0], rd[3:0], re[7:0]});
		chk(mcuPinIn, pinIn & m0);
		chk(logicIn, pinIn & {m2[35:8], 8'h00});
		chk({tms, tck, tdi}, {pinIn.e[0] & m2.e[0], pinIn.e[1] & m2.e[1], pinIn.e[2] & m2.e[2]});
		chk({adOe, adOut}, {~readStrobeN & blockSelected, rdData});
		chk(abort, 1'b0);
	endtask

	// ==========================================================
	// watchdog
	initial begin
		#120000;
		mismatches++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		#1;
		chk(pinOe, '0);
		rst = 1'b0;
		step(4);
		// rising-edge address strobe, later address change ignored
		cfgIn.d[0] = 2'h1;
		cfgIn.asRising = 1'b1;
		step(3);
		adIn = 16'h5AC3;
		step(1);
		farVal.d[0] = 1'b1;
		step(4);
		chk(latAddr, 16'h5AC3);
		adIn = 16'hA53C;
		step(4);
		chk(latAddr, 16'h5AC3);
		farVal.d[0] = 1'b0;
		expAddr = 16'h5AC3;
		// clock input, chip-select and high-byte write together
		cfgIn.d = {2'h1, 2'h1, 2'h1, 2'h1};
		farVal.d = 4'b1100;
		step(4);
		chk(memEn, 1'b0);
		ticks = 0;
		wakes = 0;
		hiWrs = 0;
		farVal.d = 4'b0010;
		step(4);
		chk(memEn, 1'b1);
		farVal.d = 4'b1000;
		step(4);
		chk(36'(ticks), 36'h1);
		chk(36'(wakes), 36'h1);
		chk(36'(hiWrs), 36'h1);
		chk(hiData, 8'hA5);
		// latched and registered logic inputs, then strobe in follow mode
		cfgIn.a = 16'hAAAA;
		cfgIn.b = 16'hAAAA;
		cfgIn.modeA = 2'h1;
		cfgIn.modeB = 2'h2;
		farVal.a = 8'h3C;
		farVal.b = 8'h96;
		step(4);
		chk({logicIn.a, logicIn.b}, 16'h0000);
		farVal.d = 4'b1011;
		step(4);
		chk({logicIn.a, logicIn.b}, 16'h3C96);
		chk(latAddr, 16'hA53C);
		cfgIn.asRising = 1'b0;
		farVal.a = 8'h00;
		farVal.b = 8'h00;
		adIn = 16'h1234;
		step(4);
		chk({logicIn.a, logicIn.b}, 16'h0096);
		chk(latAddr, 16'h1234);
		farVal.d = 4'b1000;
		expAddr = 16'h1234;
		step(4);
		// random functions, codes and sources
		repeat (60) begin
			randAll();
			step(6);
			chkPins();
		end
		// reset pin with flash busy
		nvmBusy = 1'b1;
		resetPinN = 1'b0;
		step(4);
		chk(abort, 1'b1);
		chk(pinOe, '0);
		resetPinN = 1'b1;
		nvmBusy = 1'b0;
		step(4);
		chk(abort, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
